//--- src/lod_select_regs.svh
`ifndef LOD_SELECT_REGS_SVH
`define LOD_SELECT_REGS_SVH

// ==========================================================================
// Register offsets (byte addresses on the APB port).
// ==========================================================================
`define LOD_CTRL_OFS 12'h000
`define LOD_BIAS_OFS 12'h004
`define LOD_LIMIT_OFS 12'h008
`define LOD_LEVEL_OFS 12'h00c
`define LOD_RESULT_OFS 12'h010
`define LOD_MISS_CNT_OFS 12'h014

// ==========================================================================
// Control register field positions.
// ==========================================================================
`define CTRL_PRECLAMP_EN_BIT 0
`define CTRL_PRECLAMP_API_BIT 1
`define CTRL_MAG_CLAMP_BIT 2
`define CTRL_MIP_LSB 4
`define CTRL_MAG_LSB 8
`define CTRL_MIN_LSB 12
`define CTRL_MONO_LSB 16

// ==========================================================================
// Reset values and fixed-point constants.
// ==========================================================================
`define CTRL_RESET 32'h0000_0000
`define BIAS_RESET 32'h0000_0000
`define LIMIT_RESET 32'h0e00_0000
`define LEVEL_RESET 32'h0000_0000
`define LOD_HALF 14'sh0080
`define LOD_ONE 14'sh0100

`endif

//--- src/lod_select_pkg.sv
package lod_select_pkg;

  // Inter-level filter modes.
  typedef enum logic [1:0] {
    MIP_NONE = 2'h0,
    MIP_NEAREST = 2'h1,
    MIP_LINEAR = 2'h2
  } mip_filter_t;

  // Intra-level filter types.
  typedef enum logic [2:0] {
    FILT_POINT = 3'h0,
    FILT_LINEAR = 3'h1,
    FILT_ANISO = 3'h2,
    FILT_MONO = 3'h3,
    FILT_INVALID = 3'h7
  } map_filter_t;

  // Surface kinds.
  typedef enum logic [2:0] {
    SURF_1D = 3'h0,
    SURF_2D = 3'h1,
    SURF_3D = 3'h2,
    SURF_CUBE = 3'h3,
    SURF_BUFFER = 3'h4
  } surf_kind_t;

  // Message kinds.
  typedef enum logic [1:0] {
    MSG_PLAIN = 2'h0,
    MSG_BIASED = 2'h1,
    MSG_EXPLICIT = 2'h2,
    MSG_LOAD = 2'h3
  } msg_kind_t;

  // Pipeline stage states (one-hot).
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_HOLD = 2'b10
  } out_state_t;

endpackage

//--- src/texture_lod_select.sv
`timescale 1ns/1ps
`include "lod_select_regs.svh"
// Overview of operation
// RQ1 - Total bias is state plus message bias.
// RQ2 - Bias is always added, never gated.
// RQ3 - Bias precedes clamping and min/mag decision.
// RQ4 - Pre-clamp only when its enable is set.
// RQ5 - Pre-clamp uses integer and fractional limit bits.
// RQ6 - Software keeps needed mip levels resident.
// RQ7 - Limit fractions cap boundary level weight.
// RQ8 - Base offset subtracted for min/mag decision.
// RQ9 - Non-positive level means magnify at level zero.
// RQ10 - Positive level minifies using inter-level filter.
// RQ11 - Build adjusted limits from counts and minimums.
// RQ12 - Flag miss when resource minimum exceeds count.
// RQ13 - Message kind chooses how level is formed.
// RQ14 - API pre-clamp uses adjusted limits.
// RQ15 - No-mip path clamps zero to rounded limits.
// RQ16 - Nearest mip rounds clamped level to one.
// RQ17 - Linear mip gives floor, next, and fraction.
// RQ18 - Range miss zeroes level and substitutes texels.
// RQ19 - Minify or magnify select picks intra filter.
// RQ20 - Point filter reads the single nearest texel.
// RQ21 - Linear reads 2, 4 or 8 texels.
// RQ22 - Anisotropic takes 2x2 subpixels along major axis.
// RQ23 - Monochrome only on planar one-bit format.
// RQ24 - Results register aligned with each request.
//
// Fixed point: levels are S5.8 held in 14 bits, 8 fraction bits.
// One register stage: a result follows its request by one edge.
// A state write lands between requests, never inside one.
// Level outputs carry the integer part; blend carries the fraction.
// Unsupported filter and surface pairs come out as code seven.
module texture_lod_select #(
  parameter int FRAC_W = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reqValid,
  input wire logic [13:0] reqLevel,
  input wire logic [13:0] reqMsgBias,
  input wire logic [1:0] reqMsgKind,
  input wire logic [12:0] reqPerSampleMin,
  input wire logic [2:0] reqSurfKind,
  input wire logic reqMonoFormat,
  input wire logic reqHasAlpha,
  output logic outValid,
  output logic [3:0] outLevel0,
  output logic [3:0] outLevel1,
  output logic [7:0] outBlend,
  output logic outTwoLevels,
  output logic outMagnify,
  output logic outRangeMiss,
  output logic [2:0] outFilter,
  output logic [3:0] outTexelCount,
  output logic outTexelsZero,
  output logic outAlphaOne
);

  // ========================================================================
  // APB register file.
  // ========================================================================
  // Stored sampler and surface state.
  logic [31:0] ctrl_q;
  logic [31:0] bias_q;
  logic [31:0] limit_q;
  logic [31:0] level_q;
  logic [31:0] missCnt_q;
  logic [31:0] lastResult_q;
  logic apbWrite;
  logic apbAccess;
  logic addrHit;

  // Access phase decode; setup only launches the answer.
  assign apbAccess = psel && penable;
  assign apbWrite = apbAccess && pwrite;

  // Software writes land only in the access phase, which takes one cycle.
  // Read-only offsets fall to the default, so software cannot corrupt them.
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_q <= `CTRL_RESET;
      bias_q <= `BIAS_RESET;
      limit_q <= `LIMIT_RESET;
      level_q <= `LEVEL_RESET;
    end else if (apbWrite) begin
      unique case (paddr)
        `LOD_CTRL_OFS: ctrl_q <= pwdata;
        `LOD_BIAS_OFS: bias_q <= pwdata;
        `LOD_LIMIT_OFS: limit_q <= pwdata;
        `LOD_LEVEL_OFS: level_q <= pwdata;
        default: ;
      endcase
    end
  end

  // Unmapped offsets answer with an error and drop the write.
  always_comb begin
    addrHit = 1'b1;
    unique case (paddr)
      `LOD_CTRL_OFS, `LOD_BIAS_OFS, `LOD_LIMIT_OFS, `LOD_LEVEL_OFS,
      `LOD_RESULT_OFS, `LOD_MISS_CNT_OFS: addrHit = 1'b1;
      default: addrHit = 1'b0;
    endcase
  end

  // Read data and ready are registered at the end of setup; the answer is there in the first access cycle.
  // Zero wait states, so the slave needs no wait logic.
  always_ff @(posedge clk) begin
    if (srst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addrHit;
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          `LOD_CTRL_OFS: prdata <= ctrl_q;
          `LOD_BIAS_OFS: prdata <= bias_q;
          `LOD_LIMIT_OFS: prdata <= limit_q;
          `LOD_LEVEL_OFS: prdata <= level_q;
          `LOD_RESULT_OFS: prdata <= lastResult_q;
          `LOD_MISS_CNT_OFS: prdata <= missCnt_q;
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ========================================================================
  // Field extraction.
  // ========================================================================
  // Decoded state fields; levels and limits in the S5.8 working format.
  logic preclampEnable;
  logic preclampApiStyle;
  logic magnifyClampNoMip;
  lod_select_pkg::mip_filter_t interLevelFilter;
  logic [1:0] magnifySelect;
  logic [1:0] minifySelect;
  logic [13:0] biasStateValue;
  logic [13:0] minLevelLimit;
  logic [13:0] maxLevelLimit;
  logic [13:0] baseLevelOffset;
  logic [3:0] mipLevelCount;
  logic [3:0] surfaceMinLevel;
  logic [13:0] resourceMinLevel;

  // Control bits.
  assign preclampEnable = ctrl_q[`CTRL_PRECLAMP_EN_BIT];
  assign preclampApiStyle = ctrl_q[`CTRL_PRECLAMP_API_BIT];
  assign magnifyClampNoMip = ctrl_q[`CTRL_MAG_CLAMP_BIT];
  assign interLevelFilter = lod_select_pkg::mip_filter_t'(ctrl_q[`CTRL_MIP_LSB +: 2]);
  assign magnifySelect = ctrl_q[`CTRL_MAG_LSB +: 2];
  assign minifySelect = ctrl_q[`CTRL_MIN_LSB +: 2];
  // Bias is S4.8, sign-extended to the 14-bit working width.
  assign biasStateValue = {bias_q[12], bias_q[12:0]};
  // Limits are U4.8 in the low and high halves of the limit register.
  assign minLevelLimit = {2'b00, limit_q[11:0]};
  assign maxLevelLimit = {2'b00, limit_q[27:16]};
  // Base offset is U4.1; a shift by seven puts its half step at bit seven.
  assign baseLevelOffset = {2'b00, level_q[4:0], 7'h00};
  // Count and minimums share the level register.
  assign mipLevelCount = level_q[11:8];
  assign surfaceMinLevel = level_q[15:12];
  assign resourceMinLevel = {2'b00, level_q[27:16]};

  // Signed helpers; limits are never negative, levels may be.
  function automatic logic signed [13:0] smax(input logic signed [13:0] a,
                                              input logic signed [13:0] b);
    smax = (a > b) ? a : b;
  endfunction

  // Lower of two signed levels.
  function automatic logic signed [13:0] smin(input logic signed [13:0] a,
                                              input logic signed [13:0] b);
    smin = (a < b) ? a : b;
  endfunction

  // Clearing the fraction rounds negative levels down.
  function automatic logic signed [13:0] floorLvl(input logic signed [13:0] a);
    floorLvl = {a[13:FRAC_W], {FRAC_W{1'b0}}};
  endfunction

  // Rounds up only when a fraction bit is set.
  function automatic logic signed [13:0] ceilLvl(input logic signed [13:0] a);
    ceilLvl = (a[FRAC_W-1:0] == '0) ? a : 14'(floorLvl(a) + `LOD_ONE);
  endfunction

  // ========================================================================
  // Limit adjustment and range check.
  // ========================================================================
  // Adjusted limits follow the stored state every cycle.
  logic signed [13:0] minLimRaised;
  logic signed [13:0] cntFixed;
  logic signed [13:0] adjustedMaxLevel;
  logic signed [13:0] adjustedMinLevel;
  logic signed [13:0] resMinLessSurf;
  logic resourceRangeMiss;

  always_comb begin
    // The count is an integer; it gains eight fraction bits.
    cntFixed = {2'b00, mipLevelCount, 8'h00};
    // Per-sample minimum raises the limit first.
    minLimRaised = smax(minLevelLimit, {1'b0, reqPerSampleMin}); // [RQ11]
    adjustedMaxLevel = smin(maxLevelLimit, cntFixed); // [RQ11]
    resMinLessSurf = 14'(resourceMinLevel - {2'b00, surfaceMinLevel, 8'h00});
    adjustedMinLevel = smax(smin(minLimRaised, cntFixed), resMinLessSurf); // [RQ11]
    // A resource minimum past the count is flagged, not clamped,
    // so software can see and count it.
    resourceRangeMiss = resMinLessSurf > cntFixed; // [RQ12]
  end

  // ========================================================================
  // Bias, pre-clamp, min/mag decision and level selection.
  // ========================================================================
  // The level as it leaves each stage.
  logic signed [13:0] biasedLevel;
  logic signed [13:0] clampedLevel;
  logic signed [13:0] finalLevel;
  logic signed [13:0] roundedLevel;
  logic magnifyMode;
  logic twoLevels;
  logic [7:0] blendFactor;

  always_comb begin
    // Bias is added unconditionally and ahead of every clamp. [RQ2] [RQ3]
    unique case (lod_select_pkg::msg_kind_t'(reqMsgKind))
      lod_select_pkg::MSG_BIASED:
        biasedLevel = 14'(reqLevel + biasStateValue + reqMsgBias); // [RQ1] [RQ13]
      lod_select_pkg::MSG_EXPLICIT, lod_select_pkg::MSG_LOAD:
        biasedLevel = 14'(biasStateValue + reqLevel); // [RQ13]
      default:
        biasedLevel = 14'(reqLevel + biasStateValue); // [RQ13]
    endcase
    // Pre-clamp is optional; the later clamps always apply.
    clampedLevel = biasedLevel;
    if (preclampEnable) begin // [RQ4]
      if (preclampApiStyle) begin
        clampedLevel = smax(smin(biasedLevel, adjustedMaxLevel), adjustedMinLevel); // [RQ14]
      end else begin
        clampedLevel = smax(smin(biasedLevel, maxLevelLimit), minLimRaised); // [RQ5] [RQ14]
      end
    end
    // The base offset moves only the crossover, not the level.
    magnifyMode = $signed(14'(clampedLevel - baseLevelOffset)) <= 0; // [RQ8] [RQ9]
    twoLevels = 1'b0;
    blendFactor = 8'h00;
    roundedLevel = '0;
    if ((magnifyMode && magnifyClampNoMip) || interLevelFilter == lod_select_pkg::MIP_NONE) begin
      // Magnified access with the clamp bit set, or unmipped access, falls back to level zero, then clamps. [RQ9] [RQ15]
      finalLevel = smax(smin(14'sh0000, ceilLvl(adjustedMaxLevel)),
                        floorLvl(adjustedMinLevel));
    end else if (interLevelFilter == lod_select_pkg::MIP_NEAREST) begin // [RQ10]
      roundedLevel = smax(smin(clampedLevel, ceilLvl(adjustedMaxLevel)),
                          floorLvl(adjustedMinLevel));
      finalLevel = floorLvl(14'(roundedLevel + `LOD_HALF)); // [RQ16]
    end else begin
      // Fractional limits cap the boundary level's weight through this clamp. [RQ7]
      finalLevel = smax(smin(clampedLevel, adjustedMaxLevel), adjustedMinLevel); // [RQ17]
      blendFactor = finalLevel[FRAC_W-1:0]; // [RQ17]
      twoLevels = 1'b1; // [RQ10]
    end
    // A miss overrides every path.
    if (resourceRangeMiss) begin
      finalLevel = '0; // [RQ18]
      blendFactor = 8'h00;
      twoLevels = 1'b0;
    end
  end

  // ========================================================================
  // Intra-level filter selection and texel footprint.
  // ========================================================================
  // An unsupported filter and surface pair reads as invalid,
  // so the fetch stage refuses it instead of degrading.
  lod_select_pkg::map_filter_t filterType;
  logic [3:0] texelCount;

  always_comb begin
    // The chosen select also governs layer filtering on volumes. [RQ19]
    filterType = lod_select_pkg::map_filter_t'({1'b0, magnifyMode ? magnifySelect : minifySelect});
    texelCount = 4'h1; // [RQ20]
    unique case (filterType)
      lod_select_pkg::FILT_LINEAR: begin
        unique case (lod_select_pkg::surf_kind_t'(reqSurfKind))
          lod_select_pkg::SURF_1D: texelCount = 4'h2; // [RQ21]
          lod_select_pkg::SURF_3D: texelCount = 4'h8; // [RQ21]
          lod_select_pkg::SURF_BUFFER: filterType = lod_select_pkg::FILT_INVALID; // [RQ21]
          default: texelCount = 4'h4; // [RQ21]
        endcase
      end
      lod_select_pkg::FILT_ANISO: begin
        // Each subpixel footprint is a 2x2 bilinear block. [RQ22]
        texelCount = 4'h4;
        if (reqSurfKind == lod_select_pkg::SURF_BUFFER || reqSurfKind == lod_select_pkg::SURF_3D)
          filterType = lod_select_pkg::FILT_INVALID; // [RQ22]
      end
      lod_select_pkg::FILT_MONO: begin
        // Block size comes from software as is.
        texelCount = ctrl_q[`CTRL_MONO_LSB +: 4];
        if (reqSurfKind != lod_select_pkg::SURF_2D || !reqMonoFormat)
          filterType = lod_select_pkg::FILT_INVALID; // [RQ23]
      end
      default: texelCount = 4'h1; // [RQ20]
    endcase
  end

  // ========================================================================
  // Output register stage.
  // ========================================================================
  // Results hold between requests; outValid marks a new one.

  // Every result is captured one edge after its request is issued. [RQ24]
  always_ff @(posedge clk) begin
    if (srst) begin
      outValid <= 1'b0;
      outLevel0 <= 4'h0;
      outLevel1 <= 4'h0;
      outBlend <= 8'h00;
      outTwoLevels <= 1'b0;
      outMagnify <= 1'b0;
      outRangeMiss <= 1'b0;
      outFilter <= 3'h0;
      outTexelCount <= 4'h0;
      outTexelsZero <= 1'b0;
      outAlphaOne <= 1'b0;
    end else begin
      outValid <= reqValid;
      if (reqValid) begin
        outLevel0 <= finalLevel[11:8]; // [RQ24]
        outLevel1 <= twoLevels ? 4'(finalLevel[11:8] + 4'h1) : finalLevel[11:8]; // [RQ17]
        outBlend <= blendFactor;
        outTwoLevels <= twoLevels;
        outMagnify <= magnifyMode;
        outRangeMiss <= resourceRangeMiss;
        outFilter <= filterType;
        outTexelCount <= texelCount;
        // A miss replaces fetches with zero texels, alpha one if absent. [RQ18]
        outTexelsZero <= resourceRangeMiss;
        outAlphaOne <= resourceRangeMiss && !reqHasAlpha;
      end
    end
  end

  // Last result and a saturating miss counter are visible to software.
  // Saturating keeps a long run from reading as few misses.
  always_ff @(posedge clk) begin
    if (srst) begin
      lastResult_q <= 32'h0000_0000;
      missCnt_q <= 32'h0000_0000;
    end else if (reqValid) begin
      // Packed copy of the level, flag, filter and blend port fields for software.
      lastResult_q <= {8'h00, blendFactor, 1'b0, filterType, resourceRangeMiss,
                       magnifyMode, twoLevels, 1'b0, 4'h0, finalLevel[11:8]};
      if (resourceRangeMiss && missCnt_q != 32'hffff_ffff)
        missCnt_q <= missCnt_q + 32'h0000_0001; // [RQ12]
    end
  end

endmodule // texture_lod_select

//--- bench/lod_request_source.sv
`timescale 1ns/1ps
// ======================================================================
// Front-end stand-in that issues one sample request per call of send.
module lod_request_source (
  input wire logic clk,
  output logic reqValid,
  output logic [13:0] reqLevel,
  output logic [13:0] reqMsgBias,
  output logic [1:0] reqMsgKind,
  output logic [12:0] reqPerSampleMin,
  output logic [2:0] reqSurfKind,
  output logic reqMonoFormat,
  output logic reqHasAlpha
);
  // Per-sample minimum for the next request; the bench sets it.
  logic [12:0] perSampleMin = 13'h0000;
  // Idle values at time zero.
  initial begin
    reqValid = 1'b0;
    {reqLevel, reqMsgBias, reqMsgKind, reqPerSampleMin} = '0;
    {reqSurfKind, reqMonoFormat, reqHasAlpha} = '0;
  end

  // Holds a request for one edge, then inverts the level, bias, surface and format fields so stale values never look valid.
  task automatic send(input logic [1:0] k, input logic [13:0] lv, input logic [13:0] mb,
                      input logic [2:0] sf, input logic [1:0] ma);
    @(posedge clk);
    reqValid <= 1'b1;
    reqMsgKind <= k;
    reqLevel <= lv;
    reqMsgBias <= (k == 2'h1) ? mb : 14'h0000;
    reqPerSampleMin <= perSampleMin;
    reqSurfKind <= sf;
    {reqMonoFormat, reqHasAlpha} <= ma;
    @(posedge clk);
    reqValid <= 1'b0;
    reqLevel <= ~lv;
    reqMsgBias <= ~mb;
    reqSurfKind <= ~sf;
    {reqMonoFormat, reqHasAlpha} <= ~ma;
  endtask
endmodule // lod_request_source

//--- bench/lod_select_monitor.sv
`timescale 1ns/1ps
// ======================================================================
// Checks on the result port; every result is tied to the request one edge earlier.
module lod_select_monitor (
  input wire logic clk,
  input wire logic srst,
  input wire logic reqValid,
  input wire logic [2:0] reqSurfKind,
  input wire logic reqMonoFormat,
  input wire logic reqHasAlpha,
  input wire logic outValid,
  input wire logic [3:0] outLevel0,
  input wire logic [3:0] outLevel1,
  input wire logic outTwoLevels,
  input wire logic outRangeMiss,
  input wire logic [2:0] outFilter,
  input wire logic [3:0] outTexelCount,
  input wire logic outTexelsZero,
  input wire logic outAlphaOne
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // A request followed by a quiet cycle.
  sequence sReq;
    reqValid;
  endsequence
  sequence sQuiet;
    sReq ##1 !reqValid;
  endsequence

  AST_OUT_VALID: assert property (sReq |=> outValid)
    else $error("result strobe missing after a request");
  AST_ONE_SHOT: assert property (sQuiet |=> !outValid)
    else $error("result strobe without a request");
  AST_HOLD: assert property (!reqValid |=> $stable(outLevel0) && $stable(outFilter))
    else $error("result changed with no request");
  AST_NEXT_LEVEL: assert property (outValid && outTwoLevels |-> outLevel1 == outLevel0 + 4'h1)
    else $error("second level is not first plus one");
  AST_MISS_ZERO: assert property (outValid && outRangeMiss |->
    outLevel0 == 4'h0 && outTexelsZero && outAlphaOne == !$past(reqHasAlpha))
    else $error("range miss result not zeroed");
  AST_TEXEL_3D: assert property (outValid && outFilter == lod_select_pkg::FILT_LINEAR &&
    $past(reqSurfKind) == lod_select_pkg::SURF_3D |-> outTexelCount == 4'h8)
    else $error("volume linear texel count wrong");
  AST_BUFFER_FILT: assert property (outValid && $past(reqSurfKind) == lod_select_pkg::SURF_BUFFER
    |-> outFilter != lod_select_pkg::FILT_LINEAR && outFilter != lod_select_pkg::FILT_ANISO)
    else $error("filter not allowed on buffer");
  AST_MONO_PLANAR: assert property (outValid && outFilter == lod_select_pkg::FILT_MONO |->
    $past(reqSurfKind) == lod_select_pkg::SURF_2D && $past(reqMonoFormat))
    else $error("mono filter on wrong surface");
endmodule // lod_select_monitor

bind texture_lod_select lod_select_monitor lod_select_monitor_i (.clk, .srst, .reqValid,
  .reqSurfKind, .reqMonoFormat, .reqHasAlpha, .outValid, .outLevel0, .outLevel1, .outTwoLevels,
  .outRangeMiss, .outFilter, .outTexelCount, .outTexelsZero, .outAlphaOne);

//--- bench/tb_top.sv
`timescale 1ns/1ps
`include "lod_select_regs.svh"
// ======================================================================
// Register and sample-request bench.
module tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, reqValid, reqMonoFormat, reqHasAlpha, outValid, outTwoLevels;
  logic outMagnify, outRangeMiss, outTexelsZero, outAlphaOne;
  logic [13:0] reqLevel, reqMsgBias;
  logic [1:0] reqMsgKind;
  logic [12:0] reqPerSampleMin;
  logic [2:0] reqSurfKind, outFilter;
  logic [3:0] outLevel0, outLevel1, outTexelCount;
  logic [7:0] outBlend;
  int badCount = 0;
  int comparisons = 0;

  always #12.5 clk = ~clk;

  texture_lod_select texture_lod_select_i (.clk, .srst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .reqValid, .reqLevel, .reqMsgBias, .reqMsgKind,
    .reqPerSampleMin, .reqSurfKind, .reqMonoFormat, .reqHasAlpha, .outValid, .outLevel0,
    .outLevel1, .outBlend, .outTwoLevels, .outMagnify, .outRangeMiss, .outFilter,
    .outTexelCount, .outTexelsZero, .outAlphaOne);
  lod_request_source lod_request_source_i (.clk, .reqValid, .reqLevel, .reqMsgBias,
    .reqMsgKind, .reqPerSampleMin, .reqSurfKind, .reqMonoFormat, .reqHasAlpha);

  task automatic check(input string w, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      badCount++;
      $display("wrong value %s expected %h seen %h", w, exp, seen);
    end
  endtask

  // One transfer; the request is held until pready is seen, bounded so a hang is caught.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) badCount++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wreg(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rreg(input logic [11:0] a, input logic [31:0] exp, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check("rdata", r, exp);
    check("slverr", {31'h0, e}, {31'h0, xe});
  endtask

  // Sends one request and compares the result; a count of f means do not compare it.
  task automatic run(input logic [1:0] k, input logic [13:0] lv, input logic [13:0] mb,
    input logic [2:0] sf, input logic [1:0] ma, input logic [3:0] l0, input logic [7:0] bl,
    input logic [2:0] fl, input logic [3:0] cnt, input logic [3:0] fg);
    lod_request_source_i.send(k, lv, mb, sf, ma);
    #1;
    check("valid", {31'h0, outValid}, 32'h1);
    check("level0", {28'h0, outLevel0}, {28'h0, l0});
    check("level1", {28'h0, outLevel1}, {28'h0, 4'(l0 + {3'h0, fg[3]})});
    check("blend", {24'h0, outBlend}, {24'h0, bl});
    check("filter", {29'h0, outFilter}, {29'h0, fl});
    if (cnt != 4'hf) check("count", {28'h0, outTexelCount}, {28'h0, cnt});
    check("flags", {28'h0, outTwoLevels, outMagnify, outRangeMiss, outAlphaOne}, {28'h0, fg});
    check("zero", {31'h0, outTexelsZero}, {31'h0, fg[1]});
  endtask

  task automatic endSim();
    $display("comparisons %0d mismatches %0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs under two hundred cycles.
  initial begin
    #50000;
    badCount++;
    endSim();
  end

  // Flags below are {two levels, magnify, range miss, alpha one}.
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    rreg(`LOD_CTRL_OFS, `CTRL_RESET, 1'b0);
    rreg(`LOD_LIMIT_OFS, `LIMIT_RESET, 1'b0);
    rreg(`LOD_LEVEL_OFS, `LEVEL_RESET, 1'b0);
    rreg(12'h018, 32'h0, 1'b1);
    wreg(`LOD_LEVEL_OFS, 32'h0000_0800);
    wreg(`LOD_LIMIT_OFS, 32'h0800_0000);
    wreg(`LOD_CTRL_OFS, 32'h0000_1020);
    rreg(`LOD_CTRL_OFS, 32'h0000_1020, 1'b0);
    run(2'h0, 14'h02c0, 14'h0, 3'h1, 2'h0, 4'h2, 8'hc0, 3'h1, 4'h4, 4'h8);
    run(2'h0, 14'h02c0, 14'h0, 3'h0, 2'h0, 4'h2, 8'hc0, 3'h1, 4'h2, 4'h8);
    run(2'h0, 14'h02c0, 14'h0, 3'h2, 2'h0, 4'h2, 8'hc0, 3'h1, 4'h8, 4'h8);
    wreg(`LOD_BIAS_OFS, 32'h0000_0040);
    run(2'h1, 14'h0100, 14'h0080, 3'h1, 2'h0, 4'h1, 8'hc0, 3'h1, 4'h4, 4'h8);
    run(2'h0, 14'h0100, 14'h0, 3'h1, 2'h0, 4'h1, 8'h40, 3'h1, 4'h4, 4'h8);
    run(2'h2, 14'h0300, 14'h0, 3'h1, 2'h0, 4'h3, 8'h40, 3'h1, 4'h4, 4'h8);
    wreg(`LOD_BIAS_OFS, 32'h0000_1f00);
    wreg(`LOD_CTRL_OFS, 32'h0000_1024);
    run(2'h0, 14'h0080, 14'h0, 3'h1, 2'h0, 4'h0, 8'h00, 3'h0, 4'h1, 4'h4);
    wreg(`LOD_BIAS_OFS, 32'h0000_0000);
    wreg(`LOD_LIMIT_OFS, 32'h0800_0100);
    wreg(`LOD_CTRL_OFS, 32'h0000_1025);
    run(2'h0, 14'h3f00, 14'h0, 3'h1, 2'h0, 4'h1, 8'h00, 3'h1, 4'h4, 4'h8);
    wreg(`LOD_CTRL_OFS, 32'h0000_1024);
    run(2'h0, 14'h3f00, 14'h0, 3'h1, 2'h0, 4'h1, 8'h00, 3'h0, 4'h1, 4'h4);
    wreg(`LOD_LIMIT_OFS, 32'h0800_0000);
    wreg(`LOD_LEVEL_OFS, 32'h0000_0804);
    run(2'h0, 14'h0180, 14'h0, 3'h1, 2'h0, 4'h0, 8'h00, 3'h0, 4'h1, 4'h4);
    wreg(`LOD_LEVEL_OFS, 32'h0000_0800);
    wreg(`LOD_LIMIT_OFS, 32'h0800_0480);
    wreg(`LOD_CTRL_OFS, 32'h0000_1020);
    run(2'h0, 14'h0300, 14'h0, 3'h1, 2'h0, 4'h4, 8'h80, 3'h1, 4'h4, 4'h8);
    wreg(`LOD_LIMIT_OFS, 32'h0e00_0000);
    run(2'h0, 14'h0c00, 14'h0, 3'h1, 2'h0, 4'h8, 8'h00, 3'h1, 4'h4, 4'h8);
    lod_request_source_i.perSampleMin <= 13'h0300;
    run(2'h0, 14'h0100, 14'h0, 3'h1, 2'h0, 4'h3, 8'h00, 3'h1, 4'h4, 4'h8);
    lod_request_source_i.perSampleMin <= 13'h0000;
    wreg(`LOD_LEVEL_OFS, 32'h0200_0802);
    wreg(`LOD_CTRL_OFS, 32'h0000_1023);
    run(2'h0, 14'h0080, 14'h0, 3'h1, 2'h0, 4'h2, 8'h00, 3'h1, 4'h4, 4'h8);
    wreg(`LOD_LEVEL_OFS, 32'h0000_0800);
    wreg(`LOD_CTRL_OFS, 32'h0000_1010);
    run(2'h0, 14'h0280, 14'h0, 3'h1, 2'h0, 4'h3, 8'h00, 3'h1, 4'h4, 4'h0);
    run(2'h0, 14'h0240, 14'h0, 3'h1, 2'h0, 4'h2, 8'h00, 3'h1, 4'h4, 4'h0);
    wreg(`LOD_LEVEL_OFS, 32'h0800_0800);
    run(2'h0, 14'h0100, 14'h0, 3'h1, 2'h0, 4'h8, 8'h00, 3'h1, 4'h4, 4'h0);
    wreg(`LOD_LEVEL_OFS, 32'h0900_0800);
    run(2'h0, 14'h3f00, 14'h0, 3'h1, 2'h0, 4'h0, 8'h00, 3'h0, 4'hf, 4'h7);
    run(2'h0, 14'h3f00, 14'h0, 3'h1, 2'h1, 4'h0, 8'h00, 3'h0, 4'hf, 4'h6);
    rreg(`LOD_MISS_CNT_OFS, 32'h0000_0002, 1'b0);
    wreg(`LOD_LEVEL_OFS, 32'h0000_0800);
    wreg(`LOD_CTRL_OFS, 32'h0000_2010);
    run(2'h0, 14'h0100, 14'h0, 3'h1, 2'h0, 4'h1, 8'h00, 3'h2, 4'hf, 4'h0);
    run(2'h0, 14'h0100, 14'h0, 3'h4, 2'h0, 4'h1, 8'h00, 3'h7, 4'hf, 4'h0);
    wreg(`LOD_CTRL_OFS, 32'h0000_0010);
    run(2'h0, 14'h0100, 14'h0, 3'h4, 2'h0, 4'h1, 8'h00, 3'h0, 4'h1, 4'h0);
    wreg(`LOD_CTRL_OFS, 32'h0004_3010);
    run(2'h0, 14'h0100, 14'h0, 3'h1, 2'h2, 4'h1, 8'h00, 3'h3, 4'h4, 4'h0);
    run(2'h0, 14'h0100, 14'h0, 3'h1, 2'h0, 4'h1, 8'h00, 3'h7, 4'hf, 4'h0);
    run(2'h0, 14'h0100, 14'h0, 3'h2, 2'h2, 4'h1, 8'h00, 3'h7, 4'hf, 4'h0);
    rreg(`LOD_RESULT_OFS, 32'h0000_7001, 1'b0);
    endSim();
  end
endmodule // tb_top
